// ### rtl/bmu_bitrev.sv
// Grouped bit reversal after a left shift that drops the top bits.
`timescale 1ns/1ps
`default_nettype none
module bmu_bitrev (
  input wire logic [31:0] src,
  input wire logic [4:0] pos,
  input wire logic [1:0] grp,
  output logic [31:0] rev
);

  logic [31:0] shifted;
  logic [31:0] r2;
  logic [31:0] r4;
  logic [31:0] r8;

  assign shifted = src << pos; // [RQ21]

  // Groups are taken from the top; a leftover below the last group is lost.
  always_comb
  begin
    r2 = '0;
    r4 = '0;
    r8 = '0;
    for (int j = 0; j < 32; j++)
    begin
      r2[j] = shifted[31-j];
    end
    for (int j = 0; j < 16; j++)
    begin
      r4[2*j+1 -: 2] = shifted[31-2*j -: 2];
    end
    for (int j = 0; j < 10; j++)
    begin
      r8[3*j+2 -: 3] = shifted[31-3*j -: 3];
    end
  end

  always_comb
  begin
    if (grp == bmu_pkg::GRP_R4)
    begin
      rev = r4;
    end
    else if (grp == bmu_pkg::GRP_R8)
    begin
      rev = r8;
    end
    else
    begin
      // Group code 3 falls here and reverses single bits. [RQ16]
      rev = r2;
    end
  end

endmodule : bmu_bitrev
`default_nettype wire

// ### rtl/bmu_pkg.sv
// Constants, operation codes and carrier types of the bit manipulation unit.
`default_nettype none
package bmu_pkg;

  // ****************************************************************
  // Data widths
  // ****************************************************************
  localparam int unsigned XLEN = 32;
  localparam int unsigned IDXW = 5;
  localparam int unsigned CNTW = 6;
  localparam logic [4:0] LEN_MAX = 5'h1F;
  localparam logic [63:0] MASK_SEED = 64'h0000_0000_FFFF_FFFF;
  localparam logic [31:0] NO_ONE_RESULT = 32'h0000_0020;
  localparam logic [31:0] ALL_SAME_RESULT = 32'h0000_001F;
  localparam logic [5:0] NO_ONE_INDEX = 6'h20;
  localparam logic [5:0] CLB_BASE = 6'h1E;

  // ****************************************************************
  // Instruction field positions
  // ****************************************************************
  localparam int unsigned OPC_HI = 6;
  localparam int unsigned OPC_LO = 0;
  localparam int unsigned F3_HI = 14;
  localparam int unsigned F3_LO = 12;
  localparam int unsigned F2_HI = 31;
  localparam int unsigned F2_LO = 30;
  localparam int unsigned F7_HI = 31;
  localparam int unsigned F7_LO = 25;
  localparam int unsigned LEN_HI = 29;
  localparam int unsigned LEN_LO = 25;
  localparam int unsigned POS_HI = 24;
  localparam int unsigned POS_LO = 20;
  localparam int unsigned RS2F_HI = 24;
  localparam int unsigned RS2F_LO = 20;
  localparam int unsigned BRZ_HI = 29;
  localparam int unsigned BRZ_LO = 27;
  localparam int unsigned GRP_HI = 26;
  localparam int unsigned GRP_LO = 25;
  // Length code and position inside the rs2 operand.
  localparam int unsigned RLEN_HI = 9;
  localparam int unsigned RLEN_LO = 5;
  localparam int unsigned RPOS_HI = 4;
  localparam int unsigned RPOS_LO = 0;
  localparam int unsigned AMT_HI = 4;
  localparam int unsigned AMT_LO = 0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [6:0] OPC_IMM = 7'h5B;
  localparam logic [6:0] OPC_REG = 7'h2B;
  localparam logic [2:0] F3_FIELD = 3'h0;
  localparam logic [2:0] F3_BITS = 3'h1;
  localparam logic [2:0] F3_REG = 3'h3;
  localparam logic [1:0] F2_SEXT = 2'h0;
  localparam logic [1:0] F2_UEXT = 2'h1;
  localparam logic [1:0] F2_INS = 2'h2;
  localparam logic [1:0] F2_CLR = 2'h0;
  localparam logic [1:0] F2_SET = 2'h1;
  localparam logic [1:0] F2_BREV = 2'h3;
  localparam logic [6:0] F7_SEXT = 7'h18;
  localparam logic [6:0] F7_UEXT = 7'h19;
  localparam logic [6:0] F7_INS = 7'h1A;
  localparam logic [6:0] F7_CLR = 7'h1C;
  localparam logic [6:0] F7_SET = 7'h1D;
  localparam logic [6:0] F7_ROR = 7'h20;
  localparam logic [6:0] F7_FF1 = 7'h21;
  localparam logic [6:0] F7_FL1 = 7'h22;
  localparam logic [6:0] F7_CLB = 7'h23;
  localparam logic [6:0] F7_CNT = 7'h24;
  localparam logic [4:0] RS2F_NONE = 5'h00;
  localparam logic [2:0] BRZ_NONE = 3'h0;
  localparam logic [1:0] GRP_R2 = 2'h0;
  localparam logic [1:0] GRP_R4 = 2'h1;
  localparam logic [1:0] GRP_R8 = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [11:0] {
    OP_NONE = 12'h001,
    OP_SEXT = 12'h002,
    OP_UEXT = 12'h004,
    OP_INS = 12'h008,
    OP_CLR = 12'h010,
    OP_SET = 12'h020,
    OP_BREV = 12'h040,
    OP_FF1 = 12'h080,
    OP_FL1 = 12'h100,
    OP_CLB = 12'h200,
    OP_CNT = 12'h400,
    OP_ROR = 12'h800
  } bmu_op_t;

  typedef struct packed {
    bmu_op_t op;
    logic [4:0] len;
    logic [4:0] pos;
    logic hit;
    logic illegal;
  } bmu_dec_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [31:0] data;
  } bmu_res_t;

endpackage : bmu_pkg
`default_nettype wire

// ### rtl/bmu_popcount.sv
// Population counter of one operand word.
`timescale 1ns/1ps
`default_nettype none
module bmu_popcount #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned CW = 6
) (
  input wire logic [WIDTH-1:0] src,
  output logic [CW-1:0] count
);

  always_comb
  begin
    count = '0;
    for (int i = 0; i < WIDTH; i++)
    begin
      count = count + CW'(src[i]);
    end
  end

endmodule : bmu_popcount
`default_nettype wire

// ### rtl/bmu_top.sv
// Bit manipulation unit: decode, datapath and registered result.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: Signed extract of clamped field, sign extended.
// RQ2: Unsigned extract of same field, zero extended.
// RQ3: Register extract takes length, position from rs2.
// RQ4: Insert rs1 low bits into old destination field.
// RQ5: Software keeps insert length plus position below 32.
// RQ6: Register insert takes length, position from rs2.
// RQ7: Clear forces clamped field to zero.
// RQ8: Set forces clamped field to one.
// RQ9: Register clear, set take fields from rs2.
// RQ10: Lowest set bit index, 32 when zero.
// RQ11: Highest set bit index, 32 when zero.
// RQ12: Leading equal bits minus one, zero for zero.
// RQ13: Count of one bits in rs1.
// RQ14: Rotate rs1 right by rs2.
// RQ15: Group code picks one, two, three bit groups.
// RQ16: Group code three behaves as code zero.
// RQ17: Decode immediate extract and insert forms.
// RQ18: Decode immediate clear and set forms.
// RQ19: Decode grouped reversal with zero bits 29:27.
// RQ20: Decode register forms by funct7 code.
// RQ21: Reversal first shifts left by position.
// RQ22: Instructions recognised only with extension enabled.
// RQ23: Rotate uses low five bits of rs2.
// RQ24: Each result ready after one execute cycle.
// RQ25: Unmatched encodings flagged illegal.
module bmu_top #(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic IN_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] RS1,
  input wire logic [31:0] RS2,
  input wire logic [31:0] RD_OLD,
  output logic OUT_VALID,
  output logic ILLEGAL,
  output logic [31:0] RESULT
);

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  logic [6:0] opc;
  logic [2:0] f3;
  logic [1:0] f2;
  logic [6:0] f7;
  logic [4:0] rs2f;
  bmu_pkg::bmu_dec_t dec;

  assign opc = INSTR[bmu_pkg::OPC_HI:bmu_pkg::OPC_LO];
  assign f3 = INSTR[bmu_pkg::F3_HI:bmu_pkg::F3_LO];
  assign f2 = INSTR[bmu_pkg::F2_HI:bmu_pkg::F2_LO];
  assign f7 = INSTR[bmu_pkg::F7_HI:bmu_pkg::F7_LO];
  assign rs2f = INSTR[bmu_pkg::RS2F_HI:bmu_pkg::RS2F_LO];

  always_comb
  begin
    dec.op = bmu_pkg::OP_NONE;
    dec.len = INSTR[bmu_pkg::LEN_HI:bmu_pkg::LEN_LO];
    dec.pos = INSTR[bmu_pkg::POS_HI:bmu_pkg::POS_LO];
    dec.hit = 1'b0;
    dec.illegal = 1'b0;
    if (opc == bmu_pkg::OPC_IMM && f3 == bmu_pkg::F3_FIELD)
    begin
      dec.hit = 1'b1;
      if (f2 == bmu_pkg::F2_SEXT)
        dec.op = bmu_pkg::OP_SEXT; // [RQ17]
      else if (f2 == bmu_pkg::F2_UEXT)
        dec.op = bmu_pkg::OP_UEXT; // [RQ17]
      else if (f2 == bmu_pkg::F2_INS)
        dec.op = bmu_pkg::OP_INS; // [RQ17]
      else
        dec.illegal = 1'b1; // [RQ25]
    end
    else if (opc == bmu_pkg::OPC_IMM && f3 == bmu_pkg::F3_BITS)
    begin
      dec.hit = 1'b1;
      if (f2 == bmu_pkg::F2_CLR)
        dec.op = bmu_pkg::OP_CLR; // [RQ18]
      else if (f2 == bmu_pkg::F2_SET)
        dec.op = bmu_pkg::OP_SET; // [RQ18]
      else if (f2 == bmu_pkg::F2_BREV &&
               INSTR[bmu_pkg::BRZ_HI:bmu_pkg::BRZ_LO] == bmu_pkg::BRZ_NONE)
      begin
        dec.op = bmu_pkg::OP_BREV; // [RQ19]
        dec.len = {3'h0, INSTR[bmu_pkg::GRP_HI:bmu_pkg::GRP_LO]}; // [RQ19]
      end
      else
        dec.illegal = 1'b1; // [RQ25]
    end
    else if (opc == bmu_pkg::OPC_REG && f3 == bmu_pkg::F3_REG)
    begin
      dec.hit = 1'b1;
      dec.len = RS2[bmu_pkg::RLEN_HI:bmu_pkg::RLEN_LO]; // [RQ3] [RQ6] [RQ9]
      dec.pos = RS2[bmu_pkg::RPOS_HI:bmu_pkg::RPOS_LO]; // [RQ3] [RQ6] [RQ9]
      if (f7 == bmu_pkg::F7_SEXT)
        dec.op = bmu_pkg::OP_SEXT; // [RQ20]
      else if (f7 == bmu_pkg::F7_UEXT)
        dec.op = bmu_pkg::OP_UEXT; // [RQ20]
      else if (f7 == bmu_pkg::F7_INS)
        dec.op = bmu_pkg::OP_INS; // [RQ20]
      else if (f7 == bmu_pkg::F7_CLR)
        dec.op = bmu_pkg::OP_CLR; // [RQ20]
      else if (f7 == bmu_pkg::F7_SET)
        dec.op = bmu_pkg::OP_SET; // [RQ20]
      else if (f7 == bmu_pkg::F7_ROR)
        dec.op = bmu_pkg::OP_ROR; // [RQ20]
      else if (f7 == bmu_pkg::F7_FF1 && rs2f == bmu_pkg::RS2F_NONE)
        dec.op = bmu_pkg::OP_FF1; // [RQ20]
      else if (f7 == bmu_pkg::F7_FL1 && rs2f == bmu_pkg::RS2F_NONE)
        dec.op = bmu_pkg::OP_FL1; // [RQ20]
      else if (f7 == bmu_pkg::F7_CLB && rs2f == bmu_pkg::RS2F_NONE)
        dec.op = bmu_pkg::OP_CLB; // [RQ20]
      else if (f7 == bmu_pkg::F7_CNT && rs2f == bmu_pkg::RS2F_NONE)
        dec.op = bmu_pkg::OP_CNT; // [RQ20]
      else
        dec.illegal = 1'b1; // [RQ25]
    end
    // With the extension off every encoding of these groups is refused.
    if (!CUSTOM_EXT_ENABLE && dec.hit)
    begin
      dec.op = bmu_pkg::OP_NONE; // [RQ22]
      dec.illegal = 1'b1; // [RQ22]
    end
  end

  // ****************************************************************
  // Field mask and helpers
  // ****************************************************************
  logic [63:0] mask_wide;
  logic [31:0] mask;
  logic [31:0] mask_lo;
  logic sign;
  logic [31:0] field;
  logic [5:0] lowest;
  logic [5:0] highest;
  logic [5:0] diff_top;
  logic [31:0] diff;
  logic [5:0] ones;
  logic [31:0] reversed;
  logic [63:0] rot_wide;
  logic [4:0] amt;

  // The mask stops at bit 31 by truncation, which gives the clamp.
  assign mask_wide = (bmu_pkg::MASK_SEED >> (bmu_pkg::LEN_MAX - dec.len))
                     << dec.pos;
  assign mask = mask_wide[31:0]; // [RQ1] [RQ3]
  assign mask_lo = mask >> dec.pos;
  assign sign = |(RS1 & mask & ~(mask >> 1)); // [RQ1]
  assign field = (RS1 >> dec.pos) & mask_lo;
  assign diff = RS1 ^ {32{RS1[31]}};
  assign amt = RS2[bmu_pkg::AMT_HI:bmu_pkg::AMT_LO]; // [RQ23]
  assign rot_wide = {RS1, RS1} >> amt;

  function automatic logic [5:0] top_one(input logic [31:0] x);
    logic [5:0] idx;
    idx = bmu_pkg::NO_ONE_INDEX;
    for (int i = 0; i < 32; i++)
    begin
      if (x[i])
        idx = 6'(i);
    end
    return idx;
  endfunction : top_one

  always_comb
  begin
    lowest = bmu_pkg::NO_ONE_INDEX;
    for (int i = 31; i >= 0; i--)
    begin
      if (RS1[i])
        lowest = 6'(i); // [RQ10]
    end
  end

  assign highest = top_one(RS1); // [RQ11]
  assign diff_top = top_one(diff);

  bmu_popcount #(
    .WIDTH(bmu_pkg::XLEN),
    .CW(bmu_pkg::CNTW)
  ) u_popcount (
    .src(RS1),
    .count(ones)
  );

  bmu_bitrev u_bitrev (
    .src(RS1),
    .pos(dec.pos),
    .grp(dec.len[1:0]),
    .rev(reversed)
  );

  // ****************************************************************
  // Result select
  // ****************************************************************
  logic [31:0] next_data;

  always_comb
  begin
    case (dec.op)
      bmu_pkg::OP_SEXT:
        next_data = field | (sign ? ~mask_lo : 32'h0000_0000); // [RQ1]
      bmu_pkg::OP_UEXT:
        next_data = field; // [RQ2]
      bmu_pkg::OP_INS:
        next_data = (RD_OLD & ~mask) | ((RS1 << dec.pos) & mask); // [RQ4]
      bmu_pkg::OP_CLR:
        next_data = RS1 & ~mask; // [RQ7]
      bmu_pkg::OP_SET:
        next_data = RS1 | mask; // [RQ8]
      bmu_pkg::OP_BREV:
        next_data = reversed; // [RQ15] [RQ21]
      bmu_pkg::OP_FF1:
        next_data = {26'h0, lowest}; // [RQ10]
      bmu_pkg::OP_FL1:
        next_data = {26'h0, highest}; // [RQ11]
      bmu_pkg::OP_CLB:
      begin
        if (RS1 == 32'h0000_0000)
          next_data = 32'h0000_0000; // [RQ12]
        else if (diff == 32'h0000_0000)
          next_data = bmu_pkg::ALL_SAME_RESULT; // [RQ12]
        else
          next_data = {26'h0, bmu_pkg::CLB_BASE - diff_top}; // [RQ12]
      end
      bmu_pkg::OP_CNT:
        next_data = {26'h0, ones}; // [RQ13]
      bmu_pkg::OP_ROR:
        next_data = rot_wide[31:0]; // [RQ14]
      default:
        next_data = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Result register
  // ****************************************************************
  bmu_pkg::bmu_res_t res;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      res <= '0;
    else if (IN_VALID)
      res <= {1'b1, dec.illegal, next_data}; // [RQ24]
    else
      res.valid <= 1'b0;
  end

  assign OUT_VALID = res.valid;
  assign ILLEGAL = res.illegal;
  assign RESULT = res.data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  bmu_pkg::bmu_op_t op_q;
  logic [31:0] rs1_q;
  logic [31:0] rd_q;
  logic [31:0] mask_q;
  logic [4:0] pos_q;
  logic [4:0] amt_q;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      op_q <= bmu_pkg::OP_NONE;
      rs1_q <= '0;
      rd_q <= '0;
      mask_q <= '0;
      pos_q <= '0;
      amt_q <= '0;
    end
    else if (IN_VALID)
    begin
      op_q <= dec.op;
      rs1_q <= RS1;
      rd_q <= RD_OLD;
      mask_q <= mask;
      pos_q <= dec.pos;
      amt_q <= amt;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_result_latency: assert property ( // [RQ24]
    IN_VALID |=> OUT_VALID ##1 (OUT_VALID == $past(IN_VALID)))
    else $error("result valid not one cycle after request");

  a_ff1_lowest: assert property ( // [RQ10]
    OUT_VALID && op_q == bmu_pkg::OP_FF1 |->
      (rs1_q == 32'h0000_0000) ? (RESULT == bmu_pkg::NO_ONE_RESULT) :
      (rs1_q[RESULT[4:0]] &&
       ((rs1_q & ((32'h0000_0001 << RESULT[4:0]) - 32'h0000_0001)) ==
        32'h0000_0000)))
    else $error("find first one index wrong");

  a_fl1_highest: assert property ( // [RQ11]
    OUT_VALID && op_q == bmu_pkg::OP_FL1 |->
      (rs1_q == 32'h0000_0000) ? (RESULT == bmu_pkg::NO_ONE_RESULT) :
      (rs1_q[RESULT[4:0]] && ((rs1_q >> RESULT[4:0]) == 32'h0000_0001)))
    else $error("find last one index wrong");

  a_popcount_value: assert property ( // [RQ13]
    OUT_VALID && op_q == bmu_pkg::OP_CNT |->
      RESULT == 32'($countones(rs1_q)))
    else $error("population count wrong");

  a_rotate_value: assert property ( // [RQ14]
    OUT_VALID && op_q == bmu_pkg::OP_ROR |->
      RESULT == ((rs1_q >> amt_q) | (rs1_q << (6'h20 - {1'b0, amt_q}))))
    else $error("rotate right result wrong");

  a_clear_field: assert property ( // [RQ7]
    OUT_VALID && op_q == bmu_pkg::OP_CLR |->
      (RESULT & mask_q) == 32'h0000_0000 &&
      (RESULT & ~mask_q) == (rs1_q & ~mask_q))
    else $error("clear touched bits outside field");

  a_set_field: assert property ( // [RQ8]
    OUT_VALID && op_q == bmu_pkg::OP_SET |->
      (RESULT & mask_q) == mask_q && (RESULT & ~mask_q) == (rs1_q & ~mask_q))
    else $error("set touched bits outside field");

  a_insert_keep: assert property ( // [RQ4]
    OUT_VALID && op_q == bmu_pkg::OP_INS |->
      (RESULT & ~mask_q) == (rd_q & ~mask_q) &&
      (RESULT & mask_q) == ((rs1_q << pos_q) & mask_q))
    else $error("insert result wrong");

  a_uext_zero: assert property ( // [RQ2]
    OUT_VALID && op_q == bmu_pkg::OP_UEXT |->
      (RESULT & ~(mask_q >> pos_q)) == 32'h0000_0000)
    else $error("unsigned extract left high bits set");

  a_clb_zero: assert property ( // [RQ12]
    OUT_VALID && op_q == bmu_pkg::OP_CLB && rs1_q == 32'h0000_0000 |->
      RESULT == 32'h0000_0000)
    else $error("leading bit count of zero not zero");

  a_disabled_illegal: assert property ( // [RQ22]
    IN_VALID && dec.hit && !CUSTOM_EXT_ENABLE |=> ILLEGAL)
    else $error("instruction accepted with extension off");

  c_insert_done: cover property (
    OUT_VALID && op_q == bmu_pkg::OP_INS && !ILLEGAL);
  c_bitrev_done: cover property (OUT_VALID && op_q == bmu_pkg::OP_BREV);
  c_illegal_seen: cover property (OUT_VALID && ILLEGAL);
  c_back_to_back: cover property (IN_VALID ##1 IN_VALID);

endmodule : bmu_top
`default_nettype wire

// ### tb/bit_manipulation_unit_tb_top.sv
// Self-checking bench of the bit manipulation unit.
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [31:0] r_ins = 32'h0;
  logic [31:0] r_a = 32'h0;
  logic [31:0] r_b = 32'h0;
  logic [31:0] r_o = 32'h0;
  logic in_valid;
  logic out_valid;
  logic illegal;
  logic off_illegal;
  logic [31:0] instr, rs1, rs2, rd_old, result, wb_data;
  logic [15:0] wb_count;
  int failures = 0;
  int comparisons = 0;
  int issued = 0;
  logic [31:0] last_exp = 32'h0;

  always #20 mclk = ~mclk;

  bmu_pipe_model pipe (.clk(mclk), .rst(rst), .req(req), .req_instr(r_ins),
    .req_rs1(r_a), .req_rs2(r_b), .req_rd_old(r_o), .in_valid(in_valid),
    .instr(instr), .rs1(rs1), .rs2(rs2), .rd_old(rd_old),
    .out_valid(out_valid), .result(result), .wb_data(wb_data),
    .wb_count(wb_count));
  bmu_top DUT (.MCLK(mclk), .RST(rst), .IN_VALID(in_valid), .INSTR(instr),
    .RS1(rs1), .RS2(rs2), .RD_OLD(rd_old), .OUT_VALID(out_valid),
    .ILLEGAL(illegal), .RESULT(result));
  bmu_top #(.CUSTOM_EXT_ENABLE(1'b0)) dut_off (.MCLK(mclk), .RST(rst),
    .IN_VALID(in_valid), .INSTR(instr), .RS1(rs1), .RS2(rs2),
    .RD_OLD(rd_old), .OUT_VALID(), .ILLEGAL(off_illegal), .RESULT());

  // ****************************************************************
  // Reference helpers
  // ****************************************************************
  function automatic logic [31:0] ei(input logic [1:0] f2,
      input logic [2:0] f3, input logic [4:0] l, p);
    return {f2, l, p, 5'h03, f3, 5'h01, 7'h5B};
  endfunction : ei

  function automatic logic [31:0] er(input logic [6:0] f7,
      input logic [4:0] r2);
    return {f7, r2, 5'h03, 3'h3, 5'h01, 7'h2B};
  endfunction : er

  function automatic logic [31:0] fmask(input logic [4:0] l, p);
    fmask = 32'h0;
    for (int i = 0; i < 32; i++)
      if (i >= p && i <= int'(l) + int'(p)) fmask[i] = 1'b1;
  endfunction : fmask

  function automatic logic [31:0] fext(input logic [31:0] a, m,
      input logic [4:0] p, input logic sgn);
    fext = (a & m) >> p;
    if (sgn && (a & m & ~(m >> 1)) != 32'h0) fext = fext | ~(m >> p);
  endfunction : fext

  function automatic logic [31:0] fbits(input int sel,
      input logic [31:0] a);
    int r;
    int n;
    int c;
    r = 32;
    n = 0;
    c = 0;
    for (int i = 0; i < 32; i++)
    begin
      if (sel == 0 && a[31-i]) r = 31 - i;
      if (sel == 1 && a[i]) r = i;
      if (a[31-i] == a[31] && n == i) n++;
      c += int'(a[i]);
    end
    if (sel == 2) r = (a == 32'h0) ? 0 : n - 1;
    if (sel == 3) r = c;
    return 32'(r);
  endfunction : fbits

  // Groups are taken from the top of the shifted word.
  function automatic logic [31:0] frev(input logic [31:0] a,
      input logic [4:0] p, input logic [1:0] grp);
    logic [31:0] x;
    int g;
    x = a << p;
    g = (grp == 2'h1) ? 2 : (grp == 2'h2) ? 3 : 1;
    frev = 32'h0;
    for (int i = 0; i < 32 / g; i++)
      for (int k = 0; k < g; k++)
        frev[i*g+k] = x[31-i*g-g+1+k];
  endfunction : frev

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask : check

  // Presents one request at a falling edge; the answer is due one cycle on.
  task automatic op(input logic [31:0] ins, a, b, o, exp,
      input logic ill = 1'b0);
    r_ins = ins;
    r_a = a;
    r_b = b;
    r_o = o;
    req = 1'b1;
    issued++;
    last_exp = exp;
    @(negedge mclk);
    check({31'h0, out_valid}, 32'h1);
    check({31'h0, illegal}, {31'h0, ill});
    check(result, exp);
  endtask : op

  task automatic idle;
    req = 1'b0;
    @(negedge mclk);
    check({31'h0, out_valid}, 32'h0);
    check(wb_data, last_exp);
  endtask : idle

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_field;
    logic [4:0] l, p;
    logic [31:0] a, b, o, m;
    a = 32'hC64A_5933;
    o = 32'h0F0F_3C3C;
    for (int i = 0; i < 3; i++)
    begin
      l = (i == 0) ? 5'h07 : (i == 1) ? 5'h1F : 5'h00;
      p = (i == 0) ? 5'h04 : (i == 1) ? 5'h14 : 5'h1F;
      b = {22'h3FFFFF, l, p};
      m = fmask(l, p);
      op(ei(2'h0, 3'h0, l, p), a, ~b, o, fext(a, m, p, 1'b1));
      op(ei(2'h1, 3'h0, l, p), a, ~b, o, fext(a, m, p, 1'b0));
      op(er(7'h18, 5'h1F), a, b, o, fext(a, m, p, 1'b1));
      op(er(7'h19, 5'h1F), a, b, o, fext(a, m, p, 1'b0));
      op(ei(2'h0, 3'h1, l, p), a, ~b, o, a & ~m);
      op(ei(2'h1, 3'h1, l, p), a, ~b, o, a | m);
      op(er(7'h1C, 5'h00), a, b, o, a & ~m);
      op(er(7'h1D, 5'h00), a, b, o, a | m);
      if (i != 1)
      begin
        op(ei(2'h2, 3'h0, l, p), a, ~b, o, (o & ~m) | ((a << p) & m));
        op(er(7'h1A, 5'h00), a, b, o, (o & ~m) | ((a << p) & m));
      end
    end
    idle();
  endtask : t_field

  task automatic t_count;
    logic [31:0] v [6] = '{32'h0, 32'h1, 32'h8000_0000, 32'hFFFF_FFFF,
      32'h0F00_1100, 32'hFFFF_0000};
    for (int i = 0; i < 6; i++)
      for (int s = 0; s < 4; s++)
        op(er(7'h21 + 7'(s), 5'h00), v[i], ~v[i], 32'h0, fbits(s, v[i]));
    idle();
  endtask : t_count

  task automatic t_rotate;
    logic [63:0] w;
    for (int s = 0; s < 40; s += 13)
    begin
      w = {32'hC64A_5933, 32'hC64A_5933} >> (s % 32);
      op(er(7'h20, 5'h1F), 32'hC64A_5933, 32'hFFFF_FFE0 | 32'(s), 32'h0, w[31:0]);
    end
    idle();
  endtask : t_rotate

  task automatic t_brev;
    logic [31:0] a;
    a = 32'hC64A_5933;
    op(ei(2'h3, 3'h1, 5'h02, 5'h04), a, 32'h0, 32'h0, 32'h216B_244B);
    for (int g = 0; g < 4; g++)
      for (int p = 0; p < 32; p += 9)
        op(ei(2'h3, 3'h1, 5'(g), 5'(p)), a, ~a, a, frev(a, 5'(p), 2'(g)));
    idle();
  endtask : t_brev

  task automatic t_illegal;
    logic [31:0] bad [7] = '{ei(2'h3, 3'h0, 5'h0, 5'h0),
      ei(2'h2, 3'h1, 5'h0, 5'h0), ei(2'h3, 3'h1, 5'h08, 5'h0),
      er(7'h1B, 5'h0), er(7'h21, 5'h01), er(7'h25, 5'h0), 32'h0000_3033};
    for (int i = 0; i < 7; i++)
      op(bad[i], 32'hFFFF_FFFF, 32'h3, 32'h5, 32'h0, i < 6);
    op(er(7'h24, 5'h00), 32'h0000_00F0, 32'h0, 32'h0, 32'h4);
    check({31'h0, off_illegal}, 32'h1);
    idle();
  endtask : t_illegal

  initial
  begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check({31'h0, out_valid}, 32'h0);
    check({31'h0, illegal}, 32'h0);
    check(result, 32'h0);
    t_field();
    t_count();
    t_rotate();
    t_brev();
    t_illegal();
    check({16'h0, wb_count}, 32'(issued));
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    print_verdict();
  end
endmodule : bit_manipulation_unit_tb_top
`default_nettype wire

// ### tb/bmu_pipe_model.sv
// Pipeline-side model: issues requests and collects write-backs.
`timescale 1ns/1ps
`default_nettype none
module bmu_pipe_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [31:0] req_instr,
  input wire logic [31:0] req_rs1,
  input wire logic [31:0] req_rs2,
  input wire logic [31:0] req_rd_old,
  output logic in_valid,
  output logic [31:0] instr,
  output logic [31:0] rs1,
  output logic [31:0] rs2,
  output logic [31:0] rd_old,
  input wire logic out_valid,
  input wire logic [31:0] result,
  output logic [31:0] wb_data,
  output logic [15:0] wb_count
);
  logic [31:0] junk;

  // Idle operand buses carry a pattern that changes every cycle.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      junk <= 32'h1234_5678;
    else
      junk <= ~junk ^ 32'h5A5A_A5A5;

  assign in_valid = req;
  assign instr = req ? req_instr : junk;
  assign rs1 = req ? req_rs1 : ~junk;
  assign rs2 = req ? req_rs2 : junk;
  assign rd_old = req ? req_rd_old : ~junk;

  // The register file takes each answer in the cycle it is flagged.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wb_data <= 32'h0;
      wb_count <= 16'h0;
    end
    else if (out_valid)
    begin
      wb_data <= result;
      wb_count <= wb_count + 16'h1;
    end
endmodule : bmu_pipe_model
`default_nettype wire
